// ---- hw/limit_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module limit_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Control
    input wire logic sample,
    input wire logic clear,
    input wire logic crossing,
    input wire log_store_pkg::cmp_sel_t compare_sensor_select,
    input wire logic [9:0] lim_lo,
    input wire logic [9:0] lim_hi,
    // Sensor values
    input wire logic [9:0] temp_value,
    input wire logic [5:0] batt_value,
    input wire logic [9:0] ext_sensor_one_input_value,
    input wire logic [9:0] ext_sensor_two_input_value,
    // Result
    output logic hit
);
    logic [9:0] val;
    logic [1:0] region;
    logic [1:0] prev_region;

    always_comb begin
        case (compare_sensor_select)
            log_store_pkg::SEL_TEMP: val = temp_value;
            log_store_pkg::SEL_BATT: val = {4'h0, batt_value};
            log_store_pkg::SEL_EXT_SENSOR_ONE_INPUT: val = ext_sensor_one_input_value;
            default: val = ext_sensor_two_input_value;
        endcase
    end

    // Region: 0 inside, 1 above, 2 below
    assign region = (val > lim_hi) ? 2'h1 : (val < lim_lo) ? 2'h2 : 2'h0;
    assign hit = crossing ? (region != prev_region) : (region != 2'h0);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_region <= 2'h0;
        end else if (clear) begin
            prev_region <= 2'h0;
        end else if (sample) begin
            prev_region <= region;
        end
    end
endmodule : limit_checker
`default_nettype wire

// ---- hw/log_record_storage_manager.sv ----
`include "log_store_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module log_record_storage_manager (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Triggers
    input wire logic meas_tick,
    input wire logic ext_sensor_one_input,
    input wire logic ext_sensor_two_input,
    // Sensor values
    input wire logic [9:0] temp_value,
    input wire logic [5:0] batt_value,
    input wire logic [4:0] ext_sensor_one_input_range,
    input wire logic [9:0] ext_sensor_one_input_value,
    input wire logic [4:0] ext_sensor_two_input_range,
    input wire logic [9:0] ext_sensor_two_input_value,
    input wire logic [31:0] rtc_value,
    // Measurement area write port
    output logic ee_req,
    output logic [9:0] ee_addr,
    output logic [15:0] ee_wdata,
    input wire logic ee_ack
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic log_en;
    logic rolling;
    log_store_pkg::log_mode_t mode;
    logic [3:0] sens_en;
    log_store_pkg::cmp_sel_t cmp_sel;
    logic [9:0] lim_lo;
    logic [9:0] lim_hi;
    logic [9:0] area_base;
    logic [9:0] area_size;
    logic [9:0] wptr;
    logic [15:0] meas_count;
    logic [5:0] repl;
    logic full;
    logic ovr;
    logic halted;
    log_store_pkg::wr_state_t state;
    logic [79:0] rec_buf;
    logic [2:0] rec_cnt;
    logic [2:0] idx;
    logic [9:0] rec_ptr;
    logic [69:0] grp;
    logic [2:0] grp_cnt;
    logic ext_sensor_one_input_q;
    logic ext_sensor_two_input_q;

    logic apb_wr;
    logic mapped;
    logic restart;
    logic stat_wr;
    logic irq_form;
    logic irq_trig;
    logic trig;
    logic legal;
    logic limit_form;
    logic dense_group;
    logic can_store;
    logic want;
    logic lim_hit;
    logic accept;
    logic fits;
    logic wrap_ok;
    logic store_now;
    logic overflow;
    logic [15:0] next_meas;
    logic [79:0] rec_words;
    logic [2:0] rec_len;
    logic [9:0] start_ptr;
    logic [10:0] end_ptr;

    // ----------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------
    assign pready = 1'b1;
    assign apb_wr = psel & penable & pwrite;

    always_comb begin
        case (paddr)
            `REG_CTRL, `REG_LIMITS, `REG_AREA, `REG_STATUS,
            `REG_MEAS, `REG_REPL, `REG_WPTR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = psel & penable & ~mapped;
    assign restart = apb_wr & (paddr == `REG_MEAS);
    assign stat_wr = apb_wr & (paddr == `REG_STATUS);

    // Read data captured in the setup cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `REG_CTRL: prdata <= {21'h000000, cmp_sel, sens_en, rolling, mode, log_en};
                `REG_LIMITS: prdata <= {6'h00, lim_hi, 6'h00, lim_lo};
                `REG_AREA: prdata <= {6'h00, area_size, 6'h00, area_base};
                `REG_STATUS: prdata <= {25'h0000000, full, ovr, 3'h0, halted,
                                        state == log_store_pkg::ST_WRITE};
                `REG_MEAS: prdata <= {16'h0000, meas_count};
                `REG_REPL: prdata <= {26'h0000000, repl};
                `REG_WPTR: prdata <= {22'h000000, wptr};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            log_en <= 1'b0;
            mode <= log_store_pkg::MODE_DENSE;
            rolling <= 1'b0;
            sens_en <= `SENS_RST;
            cmp_sel <= log_store_pkg::SEL_TEMP;
            lim_lo <= `LOWER_RST;
            lim_hi <= `UPPER_RST;
            area_base <= `AREA_BASE_RST;
            area_size <= `AREA_SIZE_RST;
        end else if (apb_wr) begin
            case (paddr)
                `REG_CTRL: begin
                    log_en <= pwdata[`CTRL_EN];
                    mode <= log_store_pkg::log_mode_t'(pwdata[`CTRL_MODE_LSB +: 3]);
                    rolling <= pwdata[`CTRL_ROLL];
                    sens_en <= pwdata[`CTRL_SENS_LSB +: 4];
                    cmp_sel <= log_store_pkg::cmp_sel_t'(pwdata[`CTRL_CMP_LSB +: 2]);
                end
                `REG_LIMITS: begin
                    lim_lo <= pwdata[9:0];
                    lim_hi <= pwdata[25:16];
                end
                `REG_AREA: begin
                    area_base <= pwdata[9:0];
                    area_size <= pwdata[25:16];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // Trigger selection
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_sensor_one_input_q <= 1'b0;
            ext_sensor_two_input_q <= 1'b0;
        end else begin
            ext_sensor_one_input_q <= ext_sensor_one_input;
            ext_sensor_two_input_q <= ext_sensor_two_input;
        end
    end

    assign irq_form = mode[2] & (mode != log_store_pkg::MODE_RFU_B);

    always_comb begin
        case (mode)
            log_store_pkg::MODE_IRQ_ONE: irq_trig = ext_sensor_one_input & ~ext_sensor_one_input_q;
            log_store_pkg::MODE_IRQ_TWO: irq_trig = ext_sensor_two_input & ~ext_sensor_two_input_q;
            log_store_pkg::MODE_IRQ_BOTH: irq_trig = (ext_sensor_one_input & ~ext_sensor_one_input_q)
                                                   | (ext_sensor_two_input & ~ext_sensor_two_input_q);
            default: irq_trig = 1'b0;
        endcase
    end

    assign trig = log_en & (irq_form ? irq_trig : meas_tick);
    assign legal = (mode != log_store_pkg::MODE_RFU_A) && (mode != log_store_pkg::MODE_RFU_B);
    assign limit_form = (mode == log_store_pkg::MODE_OUT_OF_LIMITS) || (mode == log_store_pkg::MODE_CROSSING);
    assign dense_group = (mode == log_store_pkg::MODE_DENSE) && (sens_en == `TEMP_ONLY);
    assign next_meas = meas_count + 16'h0001;

    // ----------------------------------------
    // Record building and limit check
    // ----------------------------------------
    limit_checker u_limit_checker (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .sample(trig & limit_form),
        .clear(restart),
        .crossing(mode == log_store_pkg::MODE_CROSSING),
        .compare_sensor_select(cmp_sel),
        .lim_lo(lim_lo),
        .lim_hi(lim_hi),
        .temp_value(temp_value),
        .batt_value(batt_value),
        .ext_sensor_one_input_value(ext_sensor_one_input_value),
        .ext_sensor_two_input_value(ext_sensor_two_input_value),
        .hit(lim_hit)
    );

    record_packer u_record_packer (
        .mode(mode),
        .sens_en(sens_en),
        .temp_value(temp_value),
        .batt_value(batt_value),
        .ext_sensor_one_input_range(ext_sensor_one_input_range),
        .ext_sensor_one_input_value(ext_sensor_one_input_value),
        .ext_sensor_two_input_range(ext_sensor_two_input_range),
        .ext_sensor_two_input_value(ext_sensor_two_input_value),
        .rtc_value(rtc_value),
        .meas_num(next_meas),
        .group({grp, temp_value}),
        .rec_words(rec_words),
        .rec_len(rec_len)
    );

    // ----------------------------------------
    // Store decision
    // ----------------------------------------
    always_comb begin
        if (dense_group) begin
            want = (grp_cnt == `GROUP_LAST);
        end else if (limit_form) begin
            want = lim_hit;
        end else begin
            want = irq_form | (mode == log_store_pkg::MODE_DENSE);
        end
    end

    assign can_store = legal & ~halted & ~(full & ~rolling) & (state == log_store_pkg::ST_IDLE);
    assign accept = trig & can_store & want;
    assign end_ptr = {1'b0, wptr} + {8'h00, rec_len};
    assign fits = end_ptr <= {1'b0, area_size};
    assign wrap_ok = rolling & (repl != `REPL_LAST);
    assign overflow = accept & ~fits;
    assign store_now = accept & (fits | wrap_ok);
    assign start_ptr = fits ? wptr : 10'h000;

    // ----------------------------------------
    // Counters and status flags
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meas_count <= 16'h0000;
        end else if (restart) begin
            meas_count <= 16'h0000;
        end else if (trig) begin
            meas_count <= next_meas;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            repl <= 6'h00;
            halted <= 1'b0;
        end else if (restart) begin
            repl <= 6'h00;
            halted <= 1'b0;
        end else if (overflow & rolling) begin
            repl <= repl + 6'h01;
            halted <= (repl == `REPL_LAST);
        end
    end

    // Hardware set wins over a software clear
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            full <= 1'b0;
            ovr <= 1'b0;
        end else if (restart) begin
            full <= 1'b0;
            ovr <= 1'b0;
        end else begin
            full <= overflow | (full & ~(stat_wr & pwdata[`STAT_FULL]));
            ovr <= (overflow & rolling) | (ovr & ~(stat_wr & pwdata[`STAT_OVR]));
        end
    end

    // Dense temperature-only group collection
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            grp <= 70'h0;
            grp_cnt <= 3'h0;
        end else if (restart | ~dense_group) begin
            grp <= 70'h0;
            grp_cnt <= 3'h0;
        end else if (trig & can_store) begin
            grp <= {grp[59:0], temp_value};
            grp_cnt <= grp_cnt + 3'h1;
        end
    end

    // ----------------------------------------
    // Measurement area writer
    // ----------------------------------------
    assign ee_req = (state == log_store_pkg::ST_WRITE);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= log_store_pkg::ST_IDLE;
            rec_buf <= 80'h0;
            rec_cnt <= 3'h0;
            idx <= 3'h0;
            rec_ptr <= 10'h000;
            ee_addr <= 10'h000;
            ee_wdata <= 16'h0000;
        end else if (restart) begin
            state <= log_store_pkg::ST_IDLE;
        end else begin
            case (state)
                log_store_pkg::ST_IDLE: begin
                    if (store_now) begin
                        rec_buf <= {rec_words[63:0], 16'h0000};
                        rec_cnt <= rec_len;
                        idx <= 3'h0;
                        rec_ptr <= start_ptr;
                        ee_addr <= area_base + start_ptr;
                        ee_wdata <= rec_words[79:64];
                        state <= log_store_pkg::ST_WRITE;
                    end
                end
                log_store_pkg::ST_WRITE: begin
                    if (ee_ack) begin
                        if (idx == rec_cnt - 3'h1) begin
                            state <= log_store_pkg::ST_IDLE;
                        end else begin
                            idx <= idx + 3'h1;
                            ee_addr <= ee_addr + 10'h001;
                            ee_wdata <= rec_buf[79:64];
                            rec_buf <= {rec_buf[63:0], 16'h0000};
                        end
                    end
                end
                default: state <= log_store_pkg::ST_IDLE;
            endcase
        end
    end

    // Pointer moves once the last block is acknowledged
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wptr <= 10'h000;
        end else if (restart) begin
            wptr <= 10'h000;
        end else if (ee_req & ee_ack & (idx == rec_cnt - 3'h1)) begin
            wptr <= rec_ptr + {7'h00, rec_cnt};
        end
    end
endmodule : log_record_storage_manager
`default_nettype wire

// ---- hw/log_store_pkg.sv ----
package log_store_pkg;
    typedef enum logic [2:0] {
        MODE_DENSE = 3'h0,
        MODE_OUT_OF_LIMITS = 3'h1,
        MODE_RFU_A = 3'h2,
        MODE_CROSSING = 3'h3,
        MODE_RFU_B = 3'h4,
        MODE_IRQ_ONE = 3'h5,
        MODE_IRQ_TWO = 3'h6,
        MODE_IRQ_BOTH = 3'h7
    } log_mode_t;

    typedef enum logic [1:0] {
        SEL_TEMP = 2'h0,
        SEL_BATT = 2'h1,
        SEL_EXT_SENSOR_ONE_INPUT = 2'h2,
        SEL_EXT_SENSOR_TWO_INPUT = 2'h3
    } cmp_sel_t;

    typedef enum {ST_IDLE, ST_WRITE} wr_state_t;
endpackage : log_store_pkg

// ---- hw/log_store_regs.svh ----
`ifndef LOG_STORE_REGS_SVH
`define LOG_STORE_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_LIMITS 12'h004
`define REG_AREA 12'h008
`define REG_STATUS 12'h00C
`define REG_MEAS 12'h010
`define REG_REPL 12'h014
`define REG_WPTR 12'h018

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_EN 0
`define CTRL_MODE_LSB 1
`define CTRL_ROLL 4
`define CTRL_SENS_LSB 5
`define CTRL_CMP_LSB 9
`define STAT_BUSY 0
`define STAT_HALT 1
`define STAT_OVR 5
`define STAT_FULL 6

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define AREA_BASE_RST 10'h000
`define AREA_SIZE_RST 10'h20E
`define UPPER_RST 10'h3FF
`define LOWER_RST 10'h000
`define SENS_RST 4'h1
`define REPL_MAX 6'h3F
`define REPL_LAST 6'h3E
`define GROUP_LAST 3'h7
`define GROUP_BLOCKS 3'h5
`define TEMP_ONLY 4'h1

`endif

// ---- hw/record_packer.sv ----
`include "log_store_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module record_packer (
    // Form selection
    input wire log_store_pkg::log_mode_t mode,
    input wire logic [3:0] sens_en,
    // Sensor values
    input wire logic [9:0] temp_value,
    input wire logic [5:0] batt_value,
    input wire logic [4:0] ext_sensor_one_input_range,
    input wire logic [9:0] ext_sensor_one_input_value,
    input wire logic [4:0] ext_sensor_two_input_range,
    input wire logic [9:0] ext_sensor_two_input_value,
    input wire logic [31:0] rtc_value,
    input wire logic [15:0] meas_num,
    input wire logic [79:0] group,
    // Record, first block in the top bits
    output logic [79:0] rec_words,
    output logic [2:0] rec_len
);
    logic [15:0] ext_sensor_one_input_blk;
    logic [15:0] ext_sensor_two_input_blk;
    logic [15:0] bt_blk;
    logic [15:0] slot [0:4];
    logic [2:0] n;
    logic limits;

    assign ext_sensor_one_input_blk = {1'b1, ext_sensor_one_input_range, ext_sensor_one_input_value};
    assign ext_sensor_two_input_blk = {1'b1, ext_sensor_two_input_range, ext_sensor_two_input_value};
    assign bt_blk = {sens_en[1] ? batt_value : 6'h00, sens_en[0] ? temp_value : 10'h000};
    assign limits = (mode == log_store_pkg::MODE_OUT_OF_LIMITS) || (mode == log_store_pkg::MODE_CROSSING);

    always_comb begin
        for (int i = 0; i < 5; i++) begin
            slot[i] = 16'h0000;
        end
        n = 3'h0;
        if (mode[2]) begin
            slot[0] = ext_sensor_one_input_blk;
            slot[1] = ext_sensor_two_input_blk;
            slot[2] = bt_blk;
            slot[3] = rtc_value[31:16];
            slot[4] = rtc_value[15:0];
            n = 3'h5;
        end else if (mode == log_store_pkg::MODE_DENSE && sens_en == `TEMP_ONLY) begin
            for (int i = 0; i < 5; i++) begin
                slot[i] = group[79 - 16 * i -: 16];
            end
            n = `GROUP_BLOCKS;
        end else begin
            if (sens_en[2]) begin
                slot[n] = ext_sensor_one_input_blk;
                n = n + 3'h1;
            end
            if (sens_en[3]) begin
                slot[n] = ext_sensor_two_input_blk;
                n = n + 3'h1;
            end
            if (sens_en[1:0] != 2'h0) begin
                slot[n] = bt_blk;
                n = n + 3'h1;
            end
            if (limits) begin
                slot[n] = meas_num;
                n = n + 3'h1;
            end
        end
        rec_words = {slot[0], slot[1], slot[2], slot[3], slot[4]};
        rec_len = n;
    end
endmodule : record_packer
`default_nettype wire

// ---- verification/log_record_storage_manager_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module log_record_storage_manager_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Triggers
    input wire logic meas_tick,
    input wire logic ext_sensor_one_input,
    input wire logic ext_sensor_two_input,
    // Area port
    input wire logic ee_req,
    input wire logic [9:0] ee_addr,
    input wire logic [15:0] ee_wdata,
    input wire logic ee_ack
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    logic [2:0] blk;

    // Blocks accepted within the current record
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            blk <= 3'h0;
        end else if (!ee_req) begin
            blk <= 3'h0;
        end else if (ee_ack) begin
            blk <= blk + 3'h1;
        end
    end

    sequence s_access;
        psel && penable;
    endsequence
    sequence s_word_done;
        ee_req && ee_ack;
    endsequence

    a_apb_ready: assert property (s_access |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (s_access ##0 (paddr > 12'h018) |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("pslverr outside access");
    a_word_hold: assert property (ee_req && !ee_ack |=> ee_req && $stable(ee_addr) && $stable(ee_wdata))
        else $error("word changed before ack");
    a_block_step: assert property (s_word_done ##1 ee_req |-> ee_addr == $past(ee_addr) + 10'h001)
        else $error("blocks not consecutive");
    a_req_cause: assert property ($rose(ee_req) |-> $past(meas_tick)
        || ($past(ext_sensor_one_input) && !$past(ext_sensor_one_input, 2))
        || ($past(ext_sensor_two_input) && !$past(ext_sensor_two_input, 2)))
        else $error("record without trigger");
    a_record_len: assert property (ee_req |-> blk < 3'h5)
        else $error("record longer than five blocks");
    a_req_release: assert property (s_word_done ##0 (blk == 3'h4) |=> !ee_req)
        else $error("request held after fifth block");
endmodule : log_record_storage_manager_chk

bind log_record_storage_manager log_record_storage_manager_chk u_log_record_storage_manager_chk (.*);
`default_nettype wire

// ---- verification/log_record_storage_manager_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module log_record_storage_manager_tb;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic meas_tick = 1'b0;
    logic ext_sensor_one_input = 1'b0;
    logic ext_sensor_two_input = 1'b0;
    logic [9:0] temp_value = 10'h300;
    logic [5:0] batt_value = 6'h2A;
    logic [4:0] ext_sensor_one_input_range = 5'h15;
    logic [9:0] ext_sensor_one_input_value = 10'h155;
    logic [4:0] ext_sensor_two_input_range = 5'h0A;
    logic [9:0] ext_sensor_two_input_value = 10'h2AA;
    logic [31:0] rtc_value = 32'h1234ABCD;
    logic ee_req;
    logic [9:0] ee_addr;
    logic [15:0] ee_wdata;
    logic ee_ack;
    logic slow = 1'b0;
    logic [31:0] rd;
    logic er;
    logic [79:0] grp = 80'h0;
    logic [15:0] exp5 [5] = '{16'hD555, 16'hAAAA, 16'hAB00, 16'h1234, 16'hABCD};
    int writes = 0;
    int base_w;
    int cyc = 0;
    int bad_count = 0;
    int checked = 0;

    log_record_storage_manager u_log_record_storage_manager (.*);
    meas_area_model u_meas_area_model (.*);

    always #2.5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (ee_req && ee_ack) begin
            writes++;
        end
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize();
        if (bad_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (!pready) @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, rd, e);
    endtask : rchk

    task automatic mchk(input logic [9:0] a, input logic [15:0] e);
        chk("mem", {16'h0, u_meas_area_model.mem[a]}, {16'h0, e});
    endtask : mchk

    // One trigger, then wait for the record to finish
    task automatic trig(input logic ext);
        @(posedge core_clk);
        meas_tick <= !ext;
        ext_sensor_one_input <= ext;
        @(posedge core_clk);
        meas_tick <= 1'b0;
        ext_sensor_one_input <= 1'b0;
        repeat (3) @(posedge core_clk);
        while (ee_req) @(posedge core_clk);
    endtask : trig

    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        rchk("ctrl", 12'h000, 32'h20);
        rchk("gap", 12'h020, 32'h0);
        chk("err", {31'h0, er}, 32'h1);
        // Out-of-limits, internal sensor, normal rule
        apb(1'b1, 12'h004, 32'h02000100);
        apb(1'b1, 12'h000, 32'h63);
        trig(1'b0);
        mchk(10'h000, 16'hAB00);
        mchk(10'h001, 16'h0001);
        temp_value <= 10'h150;
        trig(1'b0);
        rchk("wptr", 12'h018, 32'h2);
        apb(1'b1, 12'h008, 32'h00030000);
        temp_value <= 10'h300;
        trig(1'b0);
        rchk("stat", 12'h00C, 32'h40);
        rchk("wptr", 12'h018, 32'h2);
        rchk("meas", 12'h010, 32'h3);
        // Interrupt form, rolling rule, slow memory
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h008, 32'h00070040);
        apb(1'b1, 12'h000, 32'h1FB);
        slow <= 1'b1;
        trig(1'b1);
        for (int i = 0; i < 5; i++) begin
            mchk(10'h040 + 10'(i), exp5[i]);
        end
        rtc_value <= 32'h56789ABC;
        trig(1'b1);
        mchk(10'h043, 16'h5678);
        rchk("stat", 12'h00C, 32'h60);
        rchk("repl", 12'h014, 32'h1);
        rchk("wptr", 12'h018, 32'h5);
        // Dense battery-only, saturation of the replacement counter
        slow <= 1'b0;
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h008, 32'h00010080);
        apb(1'b1, 12'h000, 32'h51);
        base_w = writes;
        for (int i = 0; i < 65; i++) begin
            trig(1'b0);
        end
        chk("writes", 32'(writes - base_w), 32'd63);
        mchk(10'h080, 16'hA800);
        rchk("repl", 12'h014, 32'h3F);
        rchk("stat", 12'h00C, 32'h62);
        rchk("meas", 12'h010, 32'h41);
        // Dense temperature-only group of eight
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h008, 32'h00100000);
        apb(1'b1, 12'h000, 32'h21);
        for (int i = 1; i <= 8; i++) begin
            temp_value <= 10'(i * 77);
            grp = {grp[69:0], 10'(i * 77)};
            trig(1'b0);
        end
        for (int k = 0; k < 5; k++) begin
            mchk(10'(k), grp[79 - 16 * k -: 16]);
        end
        // Crossing on external sensor one, temperature ignored
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h000, 32'h4A7);
        trig(1'b0);
        ext_sensor_one_input_value <= 10'h250;
        trig(1'b0);
        trig(1'b0);
        rchk("wptr", 12'h018, 32'h3);
        mchk(10'h000, 16'hD650);
        mchk(10'h001, 16'h0268);
        mchk(10'h002, 16'h0002);
        // Forbidden mode counts but stores nothing
        apb(1'b1, 12'h000, 32'h4A5);
        trig(1'b0);
        rchk("meas", 12'h010, 32'h4);
        rchk("wptr", 12'h018, 32'h3);
        summarize();
    end
endmodule : log_record_storage_manager_tb
`default_nettype wire

// ---- verification/meas_area_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module meas_area_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Write port
    input wire logic ee_req,
    input wire logic [9:0] ee_addr,
    input wire logic [15:0] ee_wdata,
    output logic ee_ack,
    // Pace control
    input wire logic slow
);
    logic [15:0] mem [0:1023];
    logic pace;

    // Accept one word every other cycle; when slow, only on a cycle with pace set
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ee_ack <= 1'b0;
            pace <= 1'b0;
        end else begin
            pace <= ~pace;
            ee_ack <= ee_req && !ee_ack && (!slow || pace);
        end
    end

    always_ff @(posedge core_clk) begin
        if (ee_req && ee_ack) begin
            mem[ee_addr] <= ee_wdata;
        end
    end
endmodule : meas_area_model
`default_nettype wire
